// ==== ssr_pkg.sv ====
// Purpose: Shared constants for the status reporting block.
// Assumes: Byte-wide status registers, one clock domain.
// Notes:   Bit positions are given as indices into each byte.

package ssr_pkg;

	// -------------------------------------------------------------------
	// Widths and reset values
	// -------------------------------------------------------------------
	localparam int unsigned SSR_BYTE_W      = 8;
	localparam logic [7:0]  SSR_BYTE_RST    = 8'h00;

	// -------------------------------------------------------------------
	// Status summary byte fields
	// -------------------------------------------------------------------
	localparam int unsigned SB_ERR_QUEUE    = 2;
	localparam int unsigned SB_QUES_SUM     = 3;
	localparam int unsigned SB_MSG_AVAIL    = 4;
	localparam int unsigned SB_EVENT_SUM    = 5;
	localparam int unsigned SB_MASTER_SUM   = 6;
	localparam logic [7:0]  SB_SUMMARY_MASK = 8'h3C;

	// -------------------------------------------------------------------
	// Standard event flag fields
	// -------------------------------------------------------------------
	localparam int unsigned EV_OP_DONE      = 0;
	localparam int unsigned EV_QUERY_ERR    = 2;
	localparam int unsigned EV_DEVICE_ERR   = 3;
	localparam int unsigned EV_EXEC_ERR     = 4;
	localparam int unsigned EV_SYNTAX_ERR   = 5;
	localparam int unsigned EV_POWER_ON     = 7;
	localparam logic [7:0]  EV_USED_MASK    = 8'hBD;

	// -------------------------------------------------------------------
	// Operation-complete tracking
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		OPC_IDLE = 2'b01,
		OPC_WAIT = 2'b10
	} ssr_opc_state_type;

endpackage

// ==== ssr_status_reporting.sv ====
// Purpose: Status byte and standard event reporting with service request.
// Assumes: Commands and queries arrive as one-cycle strobes on clk_i.
// Notes:   Answers to queries appear one cycle after the strobe.

`timescale 1ns/10ps

module ssr_status_reporting
	import ssr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       cmd_cls_i,
	input  wire logic       cmd_opc_i,
	input  wire logic       cmd_ese_wr_i,
	input  wire logic       cmd_sre_wr_i,
	input  wire logic [7:0] cmd_data_i,
	input  wire logic       qry_esr_i,
	input  wire logic       qry_ese_i,
	input  wire logic       qry_sre_i,
	input  wire logic       qry_stb_i,
	input  wire logic       ops_busy_i,
	input  wire logic       evt_exec_err_i,
	input  wire logic       evt_syntax_err_i,
	input  wire logic       evt_errq_empty_read_i,
	input  wire logic       evt_unread_response_i,
	input  wire logic       evt_buffers_full_i,
	input  wire logic       evt_self_test_fail_i,
	input  wire logic       evt_calib_fail_i,
	input  wire logic       evt_device_err_i,
	input  wire logic       err_queue_nonempty_i,
	input  wire logic       ques_summary_i,
	input  wire logic       out_buf_nonempty_i,
	input  wire logic       lock_key_locked_i,
	output logic            rsp_valid_o,
	output logic      [7:0] rsp_data_o,
	output logic      [7:0] status_byte_o,
	output logic      [7:0] event_flags_o,
	output logic            srq_o,
	output logic            lock_key_request_o,
	output logic            clear_status_o
);

	// -------------------------------------------------------------------
	// Helper functions
	// -------------------------------------------------------------------

	// Builds the status byte from its summary sources and the request mask.
	function automatic logic [7:0] build_status(
		input logic       errq,
		input logic       ques,
		input logic       mav,
		input logic       esb,
		input logic [7:0] mask
	);
		logic [7:0] b;
		b                = SSR_BYTE_RST;
		b[SB_ERR_QUEUE]  = errq;
		b[SB_QUES_SUM]   = ques;
		b[SB_MSG_AVAIL]  = mav;
		b[SB_EVENT_SUM]  = esb;
		b[SB_MASTER_SUM] = |(b & mask & SB_SUMMARY_MASK);
		return b;
	endfunction

	// True when any flag in a byte is set under its enable mask.
	function automatic logic any_enabled(
		input logic [7:0] flags,
		input logic [7:0] mask
	);
		return |(flags & mask);
	endfunction

	// -------------------------------------------------------------------
	// Registers and next values
	// -------------------------------------------------------------------
	logic [7:0]        esr_ff;
	logic [7:0]        nxt_esr;
	logic [7:0]        ese_ff;
	logic [7:0]        sre_ff;
	logic [7:0]        stb_ff;
	logic [7:0]        nxt_stb;
	logic              srq_ff;
	logic              rsp_valid_ff;
	logic [7:0]        rsp_data_ff;
	logic              por_pend_ff;
	logic              lock_prev_ff;
	logic              lock_seen_ff;
	logic              lock_req_ff;
	logic              cls_ff;
	ssr_opc_state_type opc_state_ff;
	logic [7:0]        raw_evt;
	logic [7:0]        set_vec;
	logic              opc_fire;
	logic              flag_clear;
	logic              lock_toggle;

	assign flag_clear  = cmd_cls_i | qry_esr_i;
	assign opc_fire    = (opc_state_ff == OPC_WAIT) && !ops_busy_i;
	assign lock_toggle = lock_seen_ff && (lock_key_locked_i != lock_prev_ff);

	// -------------------------------------------------------------------
	// Standard event flags
	// -------------------------------------------------------------------
	always_comb begin
		raw_evt                = SSR_BYTE_RST;
		raw_evt[EV_OP_DONE]    = opc_fire;
		raw_evt[EV_QUERY_ERR]  = evt_errq_empty_read_i | evt_unread_response_i
			| evt_buffers_full_i;
		raw_evt[EV_DEVICE_ERR] = evt_self_test_fail_i | evt_calib_fail_i
			| evt_device_err_i;
		raw_evt[EV_EXEC_ERR]   = evt_exec_err_i;
		raw_evt[EV_SYNTAX_ERR] = evt_syntax_err_i;
		raw_evt[EV_POWER_ON]   = por_pend_ff;
		set_vec                = raw_evt & ese_ff & EV_USED_MASK;
		// Only clear-status and the flag query clear; the reset command has no path here.
		nxt_esr = (flag_clear ? SSR_BYTE_RST : esr_ff) | set_vec;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			esr_ff <= SSR_BYTE_RST;
		end else begin
			esr_ff <= nxt_esr;
		end
	end

	// The power-on event waits until its enable bit lets it latch.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			por_pend_ff <= 1'b1;
		end else if (ese_ff[EV_POWER_ON]) begin
			por_pend_ff <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Operation-complete tracking
	// -------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			opc_state_ff <= OPC_IDLE;
		end else begin
			unique case (opc_state_ff)
				OPC_IDLE: begin
					if (cmd_opc_i) begin
						opc_state_ff <= OPC_WAIT;
					end
				end
				OPC_WAIT: begin
					if (!ops_busy_i && !cmd_opc_i) begin
						opc_state_ff <= OPC_IDLE;
					end
				end
				default: begin
					opc_state_ff <= OPC_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Enable masks
	// -------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ese_ff <= SSR_BYTE_RST;
		end else if (cmd_ese_wr_i) begin
			ese_ff <= cmd_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sre_ff <= SSR_BYTE_RST;
		end else if (cmd_sre_wr_i) begin
			sre_ff <= cmd_data_i;
		end
	end

	// -------------------------------------------------------------------
	// Status byte and service request
	// -------------------------------------------------------------------
	always_comb begin
		nxt_stb = build_status(
			err_queue_nonempty_i & !cmd_cls_i,
			ques_summary_i & !cmd_cls_i,
			out_buf_nonempty_i,
			any_enabled(nxt_esr, ese_ff),
			sre_ff);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			stb_ff <= SSR_BYTE_RST;
			srq_ff <= 1'b0;
		end else begin
			stb_ff <= nxt_stb;
			srq_ff <= any_enabled(nxt_stb, sre_ff & SB_SUMMARY_MASK);
		end
	end

	// -------------------------------------------------------------------
	// Lock key request
	// -------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			lock_prev_ff <= 1'b0;
			lock_seen_ff <= 1'b0;
		end else begin
			lock_prev_ff <= lock_key_locked_i;
			lock_seen_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			lock_req_ff <= 1'b0;
		end else begin
			lock_req_ff <= (lock_req_ff & !flag_clear) | lock_toggle;
		end
	end

	// -------------------------------------------------------------------
	// Query answers
	// -------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= SSR_BYTE_RST;
		end else begin
			rsp_valid_ff <= qry_esr_i | qry_stb_i | qry_ese_i | qry_sre_i;
			if (qry_esr_i) begin
				rsp_data_ff <= esr_ff;
			end else if (qry_stb_i) begin
				rsp_data_ff <= stb_ff;
			end else if (qry_ese_i) begin
				rsp_data_ff <= ese_ff;
			end else if (qry_sre_i) begin
				rsp_data_ff <= sre_ff;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cls_ff <= 1'b0;
		end else begin
			cls_ff <= cmd_cls_i;
		end
	end

	assign rsp_valid_o        = rsp_valid_ff;
	assign rsp_data_o         = rsp_data_ff;
	assign status_byte_o      = stb_ff;
	assign event_flags_o      = esr_ff;
	assign srq_o              = srq_ff;
	assign lock_key_request_o = lock_req_ff;
	assign clear_status_o     = cls_ff;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence opc_issue_s;
		cmd_opc_i && (opc_state_ff == OPC_IDLE);
	endsequence

	sequence opc_settle_s;
		!ops_busy_i && !cmd_opc_i && !flag_clear && ese_ff[EV_OP_DONE];
	endsequence

	flag_latch_a: assert property (evt_exec_err_i && ese_ff[EV_EXEC_ERR]
		|=> event_flags_o[EV_EXEC_ERR][*2]
			or (event_flags_o[EV_EXEC_ERR] ##1 $past(flag_clear)))
		else $error("Execution error flag did not latch.");

	flag_hold_a: assert property (event_flags_o[EV_SYNTAX_ERR] && !flag_clear
		|=> event_flags_o[EV_SYNTAX_ERR])
		else $error("Event flag dropped without a clear.");

	flag_clear_a: assert property (flag_clear && set_vec == SSR_BYTE_RST
		|=> event_flags_o == SSR_BYTE_RST && !status_byte_o[SB_EVENT_SUM])
		else $error("Event flags or their summary not cleared.");

	esr_answer_a: assert property (qry_esr_i
		|=> rsp_valid_o && rsp_data_o == $past(event_flags_o))
		else $error("Event flag query returned a wrong byte.");

	enable_gate_a: assert property (1'b1
		|=> (event_flags_o & ~$past(event_flags_o) & ~$past(ese_ff)) == SSR_BYTE_RST)
		else $error("Event flag latched while disabled.");

	mask_keep_a: assert property ((cmd_cls_i || qry_ese_i || qry_sre_i)
		&& !cmd_ese_wr_i && !cmd_sre_wr_i
		|=> ese_ff == $past(ese_ff) && sre_ff == $past(sre_ff))
		else $error("Enable mask changed without a write.");

	msg_avail_a: assert property (out_buf_nonempty_i ##1 !out_buf_nonempty_i
		|-> status_byte_o[SB_MSG_AVAIL] ##1 !status_byte_o[SB_MSG_AVAIL])
		else $error("Message available bit does not follow the buffer.");

	unused_zero_a: assert property (status_byte_o[7] == 1'b0
		&& status_byte_o[1:0] == 2'b00
		&& (event_flags_o & ~EV_USED_MASK) == SSR_BYTE_RST)
		else $error("Unused status bit reads nonzero.");

	cls_status_a: assert property (cmd_cls_i
		|=> !status_byte_o[SB_QUES_SUM] && !status_byte_o[SB_ERR_QUEUE] && clear_status_o)
		else $error("Clear-status left condition bits set.");

	master_srq_a: assert property (srq_o == status_byte_o[SB_MASTER_SUM]
		&& srq_o == |(status_byte_o & $past(sre_ff) & SB_SUMMARY_MASK))
		else $error("Master summary and service request disagree.");

	opc_done_a: assert property (opc_issue_s ##1 opc_settle_s
		|=> event_flags_o[EV_OP_DONE])
		else $error("Operation-complete flag not set after operations ended.");

	opc_busy_a: assert property ((opc_state_ff == OPC_WAIT) && ops_busy_i
		&& !event_flags_o[EV_OP_DONE] |=> !event_flags_o[EV_OP_DONE])
		else $error("Operation-complete set while operations pending.");

	lock_req_a: assert property (lock_toggle |=> lock_key_request_o)
		else $error("Lock key toggle not recorded.");

	stb_query_a: assert property (qry_stb_i && !qry_esr_i
		|=> rsp_data_o == $past(status_byte_o)
			&& status_byte_o[SB_MASTER_SUM] == |(status_byte_o & $past(sre_ff) & SB_SUMMARY_MASK))
		else $error("Status byte query answer wrong or master bit cleared.");

endmodule

// ==== ssr_host_model.sv ====
// Purpose: Remote host model that issues commands and queries as strobes.
// Assumes: One strobe per request, answers return on rsp_valid_o.
// Notes:   Strobe index 0..7 is cls, opc, ese wr, sre wr, esr, ese, sre, stb.

`timescale 1ns/10ps

module ssr_host_model (
	input  wire logic       clk_i,
	input  wire logic       rsp_valid_i,
	input  wire logic [7:0] rsp_data_i,
	output logic      [7:0] strobe_o,
	output logic      [7:0] data_o
);
	initial begin
		strobe_o = 8'h00;
		data_o   = 8'h00;
	end

	// Data is offered with every strobe, and inverted once the strobe drops.
	task automatic send(input int k, input logic [7:0] d, output logic [7:0] r, output bit ok);
		int n;
		@(posedge clk_i);
		strobe_o    <= 8'h01 << k;
		data_o      <= d;
		@(posedge clk_i);
		strobe_o <= 8'h00;
		data_o   <= ~d;
		#1;
		r  = 8'h00;
		ok = (k < 4);
		// Each answer is awaited before the next request is queued.
		for (n = 0; n < 4; n++) begin
			if (!ok && rsp_valid_i === 1'b1) begin
				r  = rsp_data_i;
				ok = 1'b1;
			end
			if (!ok) begin
				@(posedge clk_i);
				#1;
			end
		end
	endtask
endmodule

// ==== tb_ssr_status_reporting.sv ====
// Purpose: Self-checking bench for the status reporting block.
// Assumes: Requests come from the host model, events and levels from here.
// Notes:   All checks compare against values worked out from the bit map.

`timescale 1ns/10ps

module tb_ssr_status_reporting import ssr_pkg::*;;
	logic       clk_i;
	logic       rst_b_i;
	logic [7:0] strobe;
	logic [7:0] data;
	logic       ops_busy;
	logic [7:0] evt;
	logic       errq;
	logic       ques;
	logic       mav;
	logic       lock;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic [7:0] status_byte;
	logic [7:0] event_flags;
	logic       srq;
	logic       lock_req;
	logic       clr_stat;
	int         miscompares;
	int         checks;
	int unsigned ev_bit [8] = '{EV_EXEC_ERR, EV_SYNTAX_ERR, EV_QUERY_ERR, EV_QUERY_ERR,
		EV_QUERY_ERR, EV_DEVICE_ERR, EV_DEVICE_ERR, EV_DEVICE_ERR};

	always #2 clk_i = ~clk_i;

	ssr_host_model i_ssr_host_model (
		.clk_i      (clk_i),
		.rsp_valid_i(rsp_valid),
		.rsp_data_i (rsp_data),
		.strobe_o   (strobe),
		.data_o     (data)
	);

	ssr_status_reporting i_ssr_status_reporting (
		.clk_i(clk_i), .rst_b_i(rst_b_i),
		.cmd_cls_i(strobe[0]), .cmd_opc_i(strobe[1]),
		.cmd_ese_wr_i(strobe[2]), .cmd_sre_wr_i(strobe[3]), .cmd_data_i(data),
		.qry_esr_i(strobe[4]), .qry_ese_i(strobe[5]),
		.qry_sre_i(strobe[6]), .qry_stb_i(strobe[7]),
		.ops_busy_i(ops_busy), .evt_exec_err_i(evt[0]), .evt_syntax_err_i(evt[1]),
		.evt_errq_empty_read_i(evt[2]), .evt_unread_response_i(evt[3]),
		.evt_buffers_full_i(evt[4]), .evt_self_test_fail_i(evt[5]),
		.evt_calib_fail_i(evt[6]), .evt_device_err_i(evt[7]),
		.err_queue_nonempty_i(errq), .ques_summary_i(ques),
		.out_buf_nonempty_i(mav), .lock_key_locked_i(lock),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.status_byte_o(status_byte), .event_flags_o(event_flags),
		.srq_o(srq), .lock_key_request_o(lock_req), .clear_status_o(clr_stat)
	);

	// -------------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic cmd(input int k, input logic [7:0] d);
		logic [7:0] r;
		bit         ok;
		i_ssr_host_model.send(k, d, r, ok);
	endtask

	task automatic qry(input int k, input logic [7:0] exp, input string nm);
		logic [7:0] r;
		bit         ok;
		i_ssr_host_model.send(k, 8'h00, r, ok);
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen none", nm, exp);
			close_out();
		end else begin
			check(nm, exp, r);
		end
	endtask

	task automatic pulse(input int i);
		@(posedge clk_i);
		evt[i] <= 1'b1;
		@(posedge clk_i);
		evt[i] <= 1'b0;
		tick(1);
	endtask

	// -------------------------------------------------------------------
	// Test sequence
	// -------------------------------------------------------------------
	initial begin
		clk_i = 1'b0; rst_b_i = 1'b0; ops_busy = 1'b0; evt = 8'h00;
		errq = 1'b0; ques = 1'b0; mav = 1'b0; lock = 1'b0;
		miscompares = 0; checks = 0;
		tick(4);
		check("reset status", 8'h00, status_byte);
		check("reset flags", 8'h00, event_flags);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		$display("test reset done");

		cmd(2, 8'hFF);
		qry(5, 8'hFF, "ese read");
		qry(5, 8'hFF, "ese reread");
		cmd(3, 8'h20);
		tick(1);
		check("power on flag", 8'h80, event_flags);
		check("status sum", 8'h60, status_byte);
		check("srq", 8'h01, {7'h00, srq});
		qry(7, 8'h60, "stb read");
		check("stb kept", 8'h60, status_byte);
		qry(6, 8'h20, "sre read");
		qry(4, 8'h80, "esr read");
		tick(1);
		check("status cleared", 8'h00, status_byte);
		$display("test masks done");

		for (int i = 0; i < 8; i++) begin
			pulse(i);
			check("event set", 8'h01 << ev_bit[i], event_flags);
			check("event sum", 8'h60, status_byte);
			tick(2);
			check("event held", 8'h01 << ev_bit[i], event_flags);
			qry(4, 8'h01 << ev_bit[i], "esr event");
		end
		$display("test events done");

		cmd(2, 8'h00);
		pulse(0);
		check("masked event", 8'h00, event_flags);
		cmd(2, 8'h10);
		pulse(0);
		@(posedge clk_i);
		errq <= 1'b1;
		ques <= 1'b1;
		tick(2);
		cmd(0, 8'h00);
		check("cls pulse", 8'h01, {7'h00, clr_stat});
		check("cls status", 8'h00, status_byte);
		check("cls flags", 8'h00, event_flags);
		qry(5, 8'h10, "ese after cls");
		check("errq ques", 8'h0C, status_byte);
		@(posedge clk_i);
		mav <= 1'b1;
		tick(2);
		check("mav set", 8'h1C, status_byte);
		cmd(3, 8'h3C);
		tick(1);
		check("master", 8'h5C, status_byte);
		check("srq on", 8'h01, {7'h00, srq});
		@(posedge clk_i);
		mav <= 1'b0;
		tick(2);
		check("mav clear", 8'h4C, status_byte);
		cmd(3, 8'h00);
		tick(1);
		check("sre zero", 8'h0C, status_byte);
		check("srq off", 8'h00, {7'h00, srq});
		@(posedge clk_i);
		errq <= 1'b0;
		ques <= 1'b0;
		$display("test status byte done");

		cmd(2, 8'h01);
		@(posedge clk_i);
		ops_busy <= 1'b1;
		cmd(1, 8'h00);
		tick(3);
		check("opc busy", 8'h00, event_flags);
		@(posedge clk_i);
		ops_busy <= 1'b0;
		tick(3);
		check("opc done", 8'h01, event_flags);
		check("opc sum", 8'h20, status_byte);
		qry(4, 8'h01, "esr opc");
		cmd(1, 8'h00);
		tick(2);
		check("opc idle", 8'h01, event_flags);
		qry(4, 8'h01, "esr opc idle");
		$display("test opc done");

		@(posedge clk_i);
		lock <= 1'b1;
		tick(2);
		check("lock on", 8'h01, {7'h00, lock_req});
		qry(4, 8'h00, "esr lock");
		check("lock cleared", 8'h00, {7'h00, lock_req});
		@(posedge clk_i);
		lock <= 1'b0;
		tick(2);
		check("lock off", 8'h01, {7'h00, lock_req});
		$display("test lock done");
		close_out();
	end
endmodule
